// ---- design/crank_angle_tracker.sv ----
// crank angle tracker: tooth timing, sync, angle interpolation, simulator, apb registers
// How it works
// - ticks advance at rate from last interval
// - early tooth makes ticks catch up fast
// - ticks freeze at next tooth's expected value
// - crank tooth taken on rising edge
// - cam used by edge or by level
// - simulation replaces inputs, drives waveforms out
// - count to teeth total, doubled four-stroke
// - interval over limit gives stall, zero
// - skip initial teeth before feature search
// - sum intervals over length, zero stalled
// - camless start: cam picks zero or mid
// - cam required: four-stroke start only with cam seen at tooth (level or edge)
// - track only permitted, patterned, above stall
// - simulated teeth spaced by nonzero interval
// - simulated tooth high for programmed width
// - stopped host toggling shuts tracking down
// - one-cycle strobe per crank tooth, none once host toggling stops
// - unsynchronised shown whenever not tracking
// - sticky fault flags cleared by host
// - period normalised, zero while stalled
// - tooth index over cycle, evenly numbered
// - ticks per tooth 2**exp, wrap at zero
// - sync loss clears index and ticks
`timescale 1ns/100ps
`default_nettype none
module crank_angle_tracker
#(
  parameter int unsigned WATCHDOG_CYCLES = crank_tracker_pkg::WATCHDOG_CYCLES,
  parameter int unsigned EXTRAPOLATION_EXP = crank_tracker_pkg::EXTRAPOLATION_EXP
)
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // sensor pins
  input  wire logic        crank_pulse_in_i,
  input  wire logic        cam_pulse_in_i,
  // engine synchronous outputs
  output logic             simulated_crank_out_o,
  output logic             simulated_cam_out_o,
  output logic             tooth_strobe_o,
  output logic             stall_indication_o,
  output logic             unsynchronised_indication_o,
  output logic [15:0]      tooth_index_o,
  output logic [15:0]      angle_tick_counter_o
);
  localparam logic [15:0] STEP = 16'(1 << EXTRAPOLATION_EXP);

  function automatic logic [15:0] rev_pos(input logic [15:0] idx, input logic [15:0] teeth);
    rev_pos = (idx >= teeth) ? idx - teeth : idx;
  endfunction

  // registers
  crank_tracker_pkg::control_type control;
  logic [15:0] wheel_tooth_total;
  logic [15:0] gap_tooth_total;
  logic [31:0] stall_interval_limit;
  logic [15:0] initial_tooth_skip;
  logic [15:0] interval_sum_length;
  logic [31:0] simulated_tooth_interval;
  logic [31:0] simulated_tooth_width;
  logic [2:0]  fault_flag;
  logic [2:0]  fault_flag_clear;

  // apb decode
  wire wr_en = psel_i & penable_i & pwrite_i;
  wire setup = psel_i & ~penable_i;
  wire mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= crank_tracker_pkg::POSITION_OFFSET);

  // pin synchronisers, change accepted when stages two and three agree
  logic [2:0] crank_sync;
  logic [2:0] cam_sync;
  logic       crank_clean;
  logic       cam_clean;
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      crank_sync  <= 3'b000;
      cam_sync    <= 3'b000;
      crank_clean <= 1'b0;
      cam_clean   <= 1'b0;
    end
    else
    begin
      crank_sync <= {crank_sync[1:0], crank_pulse_in_i};
      cam_sync   <= {cam_sync[1:0], cam_pulse_in_i};
      if (crank_sync[1] == crank_sync[2]) crank_clean <= crank_sync[2];
      if (cam_sync[1] == cam_sync[2]) cam_clean <= cam_sync[2];
    end
  end

  // simulator
  logic [31:0] sim_count;
  logic [15:0] sim_tooth;
  logic        sim_crank;
  logic        sim_cam;
  wire         sim_run = control.simulation_select && (simulated_tooth_interval != 32'h0000_0000);
  wire [15:0]  sim_cycle = control.four_stroke ? 16'(wheel_tooth_total << 1) : wheel_tooth_total;
  wire         sim_in_gap = rev_pos(sim_tooth, wheel_tooth_total) >= wheel_tooth_total - gap_tooth_total;
  wire         sim_wrap = sim_count >= simulated_tooth_interval - 32'h0000_0001;

  // source selection
  wire crank_src = control.simulation_select ? sim_crank : crank_clean;
  wire cam_src   = control.simulation_select ? sim_cam : cam_clean;

  // tooth edge
  logic crank_prev;
  logic cam_prev;
  logic cam_latch;
  wire  tooth = crank_src & ~crank_prev;
  wire  cam_rise = cam_src & ~cam_prev;
  wire  cam_at_tooth = control.cam_edge_mode ? (cam_latch | cam_rise) : cam_src;

  // interval timing
  logic [31:0] interval_count;
  logic [31:0] last_interval;
  logic        stall;
  logic        last_gap;
  wire  [32:0] gap_threshold = {1'b0, last_interval} + {2'b00, last_interval[31:1]};
  // two gaps never follow each other, so a short first interval cannot make every later tooth a gap
  wire         gap_seen = (gap_tooth_total != 16'h0000) && ({1'b0, interval_count} > gap_threshold)
                          && (last_interval != 32'h0000_0000) && !last_gap;
  wire  [31:0] period_norm = gap_seen ? last_interval : interval_count;

  // watchdog
  logic        alive_prev;
  logic [31:0] watchdog_count;
  logic        host_ok;

  // tracking
  crank_tracker_pkg::track_state_type state;
  crank_tracker_pkg::track_state_type next_state;
  logic [15:0] skip_count;
  logic [15:0] tooth_index;
  logic [15:0] angle_tick;
  logic        catch_up;
  logic [31:0] rate_count;
  logic [31:0] summed_tooth_interval;
  logic [31:0] sum_acc;
  logic [15:0] sum_count;
  logic [31:0] period_out;
  logic        no_cam_pending;

  wire        run_ok = control.tracking_permit & ~stall & host_ok;
  wire [15:0] cycle_total = control.four_stroke ? 16'(wheel_tooth_total << 1) : wheel_tooth_total;
  wire [15:0] gap_advance = gap_seen ? gap_tooth_total : 16'h0000;
  wire [16:0] index_sum = {1'b0, tooth_index} + 17'h0_0001 + {1'b0, gap_advance};
  wire        index_wrap = index_sum >= {1'b0, cycle_total};
  wire [15:0] next_index = index_wrap ? 16'(index_sum - {1'b0, cycle_total}) : index_sum[15:0];
  wire [15:0] next_rev = rev_pos(next_index, wheel_tooth_total);
  wire        gap_due = (next_rev == 16'h0000);
  wire        early_gap = gap_seen && !gap_due; // gap before index reached it
  wire        missed_gap = !gap_seen && (gap_tooth_total != 16'h0000)
                           && (rev_pos(tooth_index, wheel_tooth_total) == wheel_tooth_total - gap_tooth_total - 16'h0001);
  wire        resync_blocked = fault_flag[crank_tracker_pkg::FAULT_EARLY_GAP]
                               | fault_flag[crank_tracker_pkg::FAULT_MISSED_GAP];
  wire        start_zero = !control.four_stroke || cam_at_tooth;
  wire        start_mid = control.four_stroke && !cam_at_tooth && control.camless_start_permit;
  wire        lock_now = (state == crank_tracker_pkg::TRACK_SEARCH) && tooth && gap_seen
                         && !resync_blocked && (start_zero || start_mid);
  wire        lose_now = (state == crank_tracker_pkg::TRACK_LOCKED) && tooth && (early_gap || missed_gap);
  wire [15:0] lock_index = start_zero ? 16'h0000 : wheel_tooth_total;
  wire [15:0] tick_base = 16'(tooth_index << EXTRAPOLATION_EXP);
  wire [15:0] lock_base = 16'(lock_index << EXTRAPOLATION_EXP);
  wire [15:0] new_base = 16'(next_index << EXTRAPOLATION_EXP);
  wire [16:0] tick_limit = {1'b0, tick_base} + {1'b0, STEP};
  wire [31:0] step_len_raw = last_interval >> EXTRAPOLATION_EXP;
  wire [31:0] step_len = (step_len_raw == 32'h0000_0000) ? 32'h0000_0001 : step_len_raw;
  wire        rate_tick = rate_count >= step_len - 32'h0000_0001;
  wire        sum_done = (sum_count + 16'h0001) >= interval_sum_length;
  wire [2:0]  fault_set = {lose_now ? 1'b0 : (tooth && gap_seen && control.four_stroke && !cam_at_tooth
                                             && no_cam_pending && state == crank_tracker_pkg::TRACK_LOCKED),
                           lose_now && missed_gap, lose_now && early_gap};

  always_comb
  begin
    next_state = state;
    case (state)
      crank_tracker_pkg::TRACK_OFF:
        if (run_ok) next_state = crank_tracker_pkg::TRACK_SKIP;
      crank_tracker_pkg::TRACK_SKIP:
        if (tooth && (skip_count + 16'h0001 >= initial_tooth_skip)) next_state = crank_tracker_pkg::TRACK_SEARCH;
      crank_tracker_pkg::TRACK_SEARCH:
        if (lock_now) next_state = crank_tracker_pkg::TRACK_LOCKED;
      crank_tracker_pkg::TRACK_LOCKED:
        if (lose_now) next_state = crank_tracker_pkg::TRACK_SEARCH;
      default:
        next_state = crank_tracker_pkg::TRACK_OFF;
    endcase
    if (!run_ok) next_state = crank_tracker_pkg::TRACK_OFF;
  end

  // timing, simulator, watchdog
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sim_count      <= 32'h0000_0000;
      sim_tooth      <= 16'h0000;
      sim_crank      <= 1'b0;
      sim_cam        <= 1'b0;
      crank_prev     <= 1'b0;
      cam_prev       <= 1'b0;
      cam_latch      <= 1'b0;
      interval_count <= 32'h0000_0000;
      last_interval  <= 32'h0000_0000;
      stall          <= 1'b1;
      last_gap       <= 1'b0;
      alive_prev     <= 1'b0;
      watchdog_count <= 32'h0000_0000;
      host_ok        <= 1'b1;
    end
    else
    begin
      if (sim_run)
      begin
        sim_count <= sim_wrap ? 32'h0000_0000 : sim_count + 32'h0000_0001;
        if (sim_wrap) sim_tooth <= (sim_tooth + 16'h0001 >= sim_cycle) ? 16'h0000 : sim_tooth + 16'h0001;
        sim_crank <= (sim_count < simulated_tooth_width) && !sim_in_gap;
        sim_cam   <= control.four_stroke && (sim_tooth >= wheel_tooth_total);
      end
      else
      begin
        sim_count <= 32'h0000_0000;
        sim_tooth <= 16'h0000;
        sim_crank <= 1'b0;
        sim_cam   <= 1'b0;
      end
      crank_prev <= crank_src;
      cam_prev   <= cam_src;
      cam_latch  <= tooth ? 1'b0 : (cam_latch | cam_rise);
      if (tooth)
      begin
        interval_count <= 32'h0000_0001; // the tooth cycle itself counts, so a spacing of n ticks reads n
        last_interval  <= period_norm;
        last_gap       <= gap_seen;
        stall          <= period_norm > stall_interval_limit;
      end
      else
      begin
        if (interval_count != 32'hFFFF_FFFF) interval_count <= interval_count + 32'h0000_0001;
        if (interval_count > stall_interval_limit) stall <= 1'b1;
      end
      alive_prev <= control.alive_toggle;
      if (control.alive_toggle != alive_prev)
        watchdog_count <= 32'h0000_0000;
      else if (watchdog_count < WATCHDOG_CYCLES)
        watchdog_count <= watchdog_count + 32'h0000_0001;
      host_ok <= watchdog_count < WATCHDOG_CYCLES;
    end
  end

  // sync, index and angle
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state          <= crank_tracker_pkg::TRACK_OFF;
      skip_count     <= 16'h0000;
      tooth_index    <= 16'h0000;
      angle_tick     <= 16'h0000;
      catch_up       <= 1'b0;
      rate_count     <= 32'h0000_0000;
      no_cam_pending <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == crank_tracker_pkg::TRACK_OFF) skip_count <= 16'h0000;
      else if (tooth && skip_count != 16'hFFFF) skip_count <= skip_count + 16'h0001;
      rate_count <= (tooth || rate_tick) ? 32'h0000_0000 : rate_count + 32'h0000_0001;
      if (next_state != crank_tracker_pkg::TRACK_LOCKED)
      begin
        tooth_index    <= 16'h0000;
        angle_tick     <= 16'h0000;
        catch_up       <= 1'b0;
        no_cam_pending <= 1'b0;
      end
      else if (lock_now)
      begin
        tooth_index <= lock_index;
        angle_tick  <= lock_base;
        catch_up    <= 1'b0;
      end
      else if (tooth)
      begin
        tooth_index <= next_index;
        if (gap_seen) no_cam_pending <= control.four_stroke && !cam_at_tooth && !no_cam_pending;
        if (next_index == 16'h0000)
        begin
          angle_tick <= 16'h0000;
          catch_up   <= 1'b0;
        end
        else
          catch_up <= angle_tick < new_base;
      end
      else if (catch_up)
      begin
        angle_tick <= angle_tick + 16'h0001;
        if (angle_tick + 16'h0001 >= tick_base) catch_up <= 1'b0;
      end
      else if (rate_tick && ({1'b0, angle_tick} < tick_limit))
        angle_tick <= angle_tick + 16'h0001;
    end
  end

  // period, sum, flags, outputs
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sum_acc                     <= 32'h0000_0000;
      sum_count                   <= 16'h0000;
      summed_tooth_interval       <= 32'h0000_0000;
      period_out                  <= 32'h0000_0000;
      fault_flag                  <= 3'b000;
      tooth_strobe_o              <= 1'b0;
      stall_indication_o          <= 1'b1;
      unsynchronised_indication_o <= 1'b1;
      tooth_index_o               <= 16'h0000;
      angle_tick_counter_o        <= 16'h0000;
      simulated_crank_out_o       <= 1'b0;
      simulated_cam_out_o         <= 1'b0;
    end
    else
    begin
      if (stall)
      begin
        sum_acc               <= 32'h0000_0000;
        sum_count             <= 16'h0000;
        summed_tooth_interval <= 32'h0000_0000;
        period_out            <= 32'h0000_0000;
      end
      else if (tooth)
      begin
        period_out <= period_norm;
        sum_acc    <= sum_done ? 32'h0000_0000 : sum_acc + period_norm;
        sum_count  <= sum_done ? 16'h0000 : sum_count + 16'h0001;
        if (sum_done) summed_tooth_interval <= sum_acc + period_norm;
      end
      fault_flag                  <= fault_set | (fault_flag & ~fault_flag_clear);
      tooth_strobe_o              <= tooth & host_ok;
      stall_indication_o          <= stall;
      unsynchronised_indication_o <= next_state != crank_tracker_pkg::TRACK_LOCKED;
      tooth_index_o               <= (next_state == crank_tracker_pkg::TRACK_LOCKED) ? tooth_index : 16'h0000;
      angle_tick_counter_o        <= (next_state == crank_tracker_pkg::TRACK_LOCKED) ? angle_tick : 16'h0000;
      simulated_crank_out_o       <= sim_crank & host_ok;
      simulated_cam_out_o         <= sim_cam & host_ok;
    end
  end

  // register writes and read data
  wire [31:0] read_mux =
    (paddr_i == crank_tracker_pkg::CONTROL_OFFSET)      ? {26'h000_0000, control} :
    (paddr_i == crank_tracker_pkg::WHEEL_OFFSET)        ? {gap_tooth_total, wheel_tooth_total} :
    (paddr_i == crank_tracker_pkg::STALL_OFFSET)        ? stall_interval_limit :
    (paddr_i == crank_tracker_pkg::SKIP_OFFSET)         ? {16'h0000, initial_tooth_skip} :
    (paddr_i == crank_tracker_pkg::SUM_LENGTH_OFFSET)   ? {16'h0000, interval_sum_length} :
    (paddr_i == crank_tracker_pkg::SIM_INTERVAL_OFFSET) ? simulated_tooth_interval :
    (paddr_i == crank_tracker_pkg::SIM_WIDTH_OFFSET)    ? simulated_tooth_width :
    (paddr_i == crank_tracker_pkg::STATUS_OFFSET)       ? {25'h000_0000, state, fault_flag,
                                                           unsynchronised_indication_o, stall_indication_o} :
    (paddr_i == crank_tracker_pkg::PERIOD_OFFSET)       ? period_out :
    (paddr_i == crank_tracker_pkg::SUM_OFFSET)          ? summed_tooth_interval :
    (paddr_i == crank_tracker_pkg::POSITION_OFFSET)     ? {tooth_index_o, angle_tick_counter_o} :
                                                           32'h0000_0000;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      control                  <= '0;
      wheel_tooth_total        <= crank_tracker_pkg::WHEEL_TOTAL_RESET;
      gap_tooth_total          <= crank_tracker_pkg::GAP_TOTAL_RESET;
      stall_interval_limit     <= crank_tracker_pkg::STALL_RESET;
      initial_tooth_skip       <= crank_tracker_pkg::SKIP_RESET;
      interval_sum_length      <= crank_tracker_pkg::SUM_LENGTH_RESET;
      simulated_tooth_interval <= crank_tracker_pkg::SIM_INTERVAL_RESET;
      simulated_tooth_width    <= crank_tracker_pkg::SIM_WIDTH_RESET;
      fault_flag_clear         <= 3'b000;
      prdata_o                 <= 32'h0000_0000;
      pready_o                 <= 1'b0;
      pslverr_o                <= 1'b0;
    end
    else
    begin
      pready_o         <= 1'b1;
      fault_flag_clear <= 3'b000;
      if (setup)
      begin
        prdata_o  <= pwrite_i ? 32'h0000_0000 : read_mux;
        pslverr_o <= !mapped;
      end
      if (wr_en && mapped)
      begin
        case (paddr_i)
          crank_tracker_pkg::CONTROL_OFFSET:      control <= pwdata_i[5:0];
          crank_tracker_pkg::WHEEL_OFFSET:
          begin
            wheel_tooth_total <= pwdata_i[15:0];
            gap_tooth_total   <= pwdata_i[31:16];
          end
          crank_tracker_pkg::STALL_OFFSET:        stall_interval_limit <= pwdata_i;
          crank_tracker_pkg::SKIP_OFFSET:         initial_tooth_skip <= pwdata_i[15:0];
          crank_tracker_pkg::SUM_LENGTH_OFFSET:   interval_sum_length <= pwdata_i[15:0];
          crank_tracker_pkg::SIM_INTERVAL_OFFSET: simulated_tooth_interval <= pwdata_i;
          crank_tracker_pkg::SIM_WIDTH_OFFSET:    simulated_tooth_width <= pwdata_i;
          crank_tracker_pkg::FLAG_CLEAR_OFFSET:   fault_flag_clear <= pwdata_i[2:0];
          default:                                fault_flag_clear <= 3'b000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- design/crank_tracker_pkg.sv ----
// shared constants and types for the crank angle tracker
package crank_tracker_pkg;
  // clock and watchdog timing
  localparam int unsigned CLOCK_HZ          = 25_000_000;
  localparam int unsigned WATCHDOG_LIMIT_MS = 250;
  localparam int unsigned WATCHDOG_CYCLES   = (CLOCK_HZ / 1000) * WATCHDOG_LIMIT_MS;
  // angle extrapolation exponent (ticks per tooth = 2**exp)
  localparam int unsigned EXTRAPOLATION_EXP = 7;
  // register byte offsets
  localparam logic [7:0] CONTROL_OFFSET     = 8'h00;
  localparam logic [7:0] WHEEL_OFFSET       = 8'h04;
  localparam logic [7:0] STALL_OFFSET       = 8'h08;
  localparam logic [7:0] SKIP_OFFSET        = 8'h0C;
  localparam logic [7:0] SUM_LENGTH_OFFSET  = 8'h10;
  localparam logic [7:0] SIM_INTERVAL_OFFSET = 8'h14;
  localparam logic [7:0] SIM_WIDTH_OFFSET   = 8'h18;
  localparam logic [7:0] FLAG_CLEAR_OFFSET  = 8'h1C;
  localparam logic [7:0] STATUS_OFFSET      = 8'h20;
  localparam logic [7:0] PERIOD_OFFSET      = 8'h24;
  localparam logic [7:0] SUM_OFFSET         = 8'h28;
  localparam logic [7:0] POSITION_OFFSET    = 8'h2C;
  // control bit positions
  localparam int unsigned CTRL_PERMIT_BIT   = 0;
  localparam int unsigned CTRL_SIM_BIT      = 1;
  localparam int unsigned CTRL_FOUR_BIT     = 2;
  localparam int unsigned CTRL_CAMLESS_BIT  = 3;
  localparam int unsigned CTRL_CAM_EDGE_BIT = 4;
  localparam int unsigned CTRL_ALIVE_BIT    = 5;
  // fault flag positions
  localparam int unsigned FAULT_EARLY_GAP   = 0;
  localparam int unsigned FAULT_MISSED_GAP  = 1;
  localparam int unsigned FAULT_NO_CAM      = 2;
  // reset values
  localparam logic [15:0] WHEEL_TOTAL_RESET = 16'h003C;
  localparam logic [15:0] GAP_TOTAL_RESET   = 16'h0002;
  localparam logic [31:0] STALL_RESET       = 32'h0001_0000;
  localparam logic [15:0] SKIP_RESET        = 16'h0002;
  localparam logic [15:0] SUM_LENGTH_RESET  = 16'h0001;
  localparam logic [31:0] SIM_INTERVAL_RESET = 32'h0000_0000;
  localparam logic [31:0] SIM_WIDTH_RESET   = 32'h0000_0010;

  typedef struct packed {
    logic alive_toggle;
    logic cam_edge_mode;
    logic camless_start_permit;
    logic four_stroke;
    logic simulation_select;
    logic tracking_permit;
  } control_type;

  typedef enum logic [1:0] {
    TRACK_OFF    = 2'b00,
    TRACK_SKIP   = 2'b01,
    TRACK_SEARCH = 2'b11,
    TRACK_LOCKED = 2'b10
  } track_state_type;
endpackage

// ---- verif/crank_sensor_model.sv ----
// sensor model: crank teeth with a missing-tooth gap and a cam level
`timescale 1ns/100ps
`default_nettype none
module crank_sensor_model
#(
  parameter int unsigned TEETH = 12,
  parameter int unsigned GAP   = 2,
  parameter int unsigned SPAN  = 300,
  parameter int unsigned WIDTH = 40
)
(
  input  wire logic clk_i,
  input  wire logic run_i,
  output logic      crank_o,
  output logic      cam_o
);
  int unsigned tick = 0;
  int unsigned pos  = 0;
  always @(posedge clk_i)
  begin
    if (run_i)
    begin
      tick <= (tick == SPAN - 1) ? 0 : tick + 1;
      if (tick == SPAN - 1)
        pos <= (pos == 2 * TEETH - 1) ? 0 : pos + 1;
    end
  end
  // gap teeth stay low; cam is high through the second revolution
  assign crank_o = run_i && (tick < WIDTH) && ((pos % TEETH) < TEETH - GAP);
  assign cam_o   = pos >= TEETH;
endmodule
`default_nettype wire

// ---- verif/crank_tracker_properties.sv ----
// concurrent checks on the crank angle tracker ports
`timescale 1ns/100ps
`default_nettype none
module crank_tracker_properties
#(
  parameter int unsigned EXTRAPOLATION_EXP = 7
)
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  // watched ports
  input wire logic        crank_pulse_in_i,
  input wire logic        simulated_crank_out_o,
  input wire logic        tooth_strobe_o,
  input wire logic        stall_indication_o,
  input wire logic        unsynchronised_indication_o,
  input wire logic [15:0] tooth_index_o,
  input wire logic [15:0] angle_tick_counter_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // angle value expected at the next tooth
  wire logic [31:0] angle_limit = (32'(tooth_index_o) + 32'd1) << EXTRAPOLATION_EXP;
  AST_STROBE_SINGLE: assert property (tooth_strobe_o |=> !tooth_strobe_o)
    else $error("tooth strobe longer than one cycle");
  AST_STROBE_SOURCE: assert property (tooth_strobe_o |-> crank_pulse_in_i || simulated_crank_out_o)
    else $error("tooth strobe without a crank pulse");
  AST_SIM_FOLLOWS: assert property ($rose(simulated_crank_out_o) |-> tooth_strobe_o)
    else $error("simulated tooth gave no strobe");
  AST_SIM_WIDTH: assert property ($rose(simulated_crank_out_o) |-> simulated_crank_out_o [*8])
    else $error("simulated tooth too short");
  AST_UNSYNC_CLEARS: assert property (unsynchronised_indication_o && $past(unsynchronised_indication_o)
    |-> tooth_index_o == 16'h0000 && angle_tick_counter_o == 16'h0000)
    else $error("index or angle not cleared while unsynchronised");
  AST_STALL_UNSYNC: assert property (stall_indication_o && $past(stall_indication_o)
    |-> unsynchronised_indication_o)
    else $error("tracking while stalled");
  AST_ANGLE_STEP: assert property (!unsynchronised_indication_o && !$past(unsynchronised_indication_o)
    && $changed(angle_tick_counter_o)
    |-> angle_tick_counter_o == $past(angle_tick_counter_o) + 16'h0001 || angle_tick_counter_o == 16'h0000)
    else $error("angle jumped");
  AST_ANGLE_CAP: assert property (!unsynchronised_indication_o && !$past(unsynchronised_indication_o)
    && $stable(tooth_index_o) && tooth_index_o == $past(tooth_index_o, 2)
    |-> 32'(angle_tick_counter_o) <= angle_limit)
    else $error("angle passed next tooth");
endmodule
bind crank_angle_tracker crank_tracker_properties #(.EXTRAPOLATION_EXP(EXTRAPOLATION_EXP)) chk_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .crank_pulse_in_i(crank_pulse_in_i),
  .simulated_crank_out_o(simulated_crank_out_o), .tooth_strobe_o(tooth_strobe_o),
  .stall_indication_o(stall_indication_o), .unsynchronised_indication_o(unsynchronised_indication_o),
  .tooth_index_o(tooth_index_o), .angle_tick_counter_o(angle_tick_counter_o));
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the crank angle tracker
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
  logic        clk_i = 0, rst_b_i = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, ctrl = '0;
  logic        pready, pslverr, err, crank, cam, sim_crank, sim_cam, strobe, stall, unsync;
  logic [15:0] index, angle, mx;
  int          n_errors = 0, cmp_count = 0, i, k;
  always #20 clk_i = ~clk_i;
  always @(negedge clk_i)
    if (index > mx) mx <= index;
  crank_angle_tracker #(.WATCHDOG_CYCLES(3100)) crank_angle_tracker_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .crank_pulse_in_i(crank), .cam_pulse_in_i(cam),
    .simulated_crank_out_o(sim_crank), .simulated_cam_out_o(sim_cam), .tooth_strobe_o(strobe),
    .stall_indication_o(stall), .unsynchronised_indication_o(unsync), .tooth_index_o(index), .angle_tick_counter_o(angle));
  crank_sensor_model crank_sensor_model_inst (.clk_i(clk_i), .run_i(run), .crank_o(crank), .cam_o(cam));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    for (j = 0; j < 16; j++)
    begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (j == 16) `CHK(pready, 1'b1)
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, '0);
    `CHK(rd, e)
  endtask
  task automatic kick(input int n);
    ctrl[crank_tracker_pkg::CTRL_ALIVE_BIT] = ~ctrl[crank_tracker_pkg::CTRL_ALIVE_BIT];
    apb(1, crank_tracker_pkg::CONTROL_OFFSET, ctrl);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_sync();
    for (i = 0; i < 60 && unsync !== 1'b0; i++) kick(100);
    `CHK(unsync, 1'b0)
  endtask
  task automatic wait_idx(input logic [15:0] v);
    kick(1);
    for (i = 0; i < 3000 && index !== v; i++) @(negedge clk_i);
    `CHK(index, v)
  endtask
  task automatic sim_rise();
    for (i = 0; i < 800 && sim_crank !== 1'b0; i++) @(negedge clk_i);
    for (i = 0; i < 800 && sim_crank !== 1'b1; i++) @(negedge clk_i);
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1;
    chk_rd(crank_tracker_pkg::STATUS_OFFSET, 32'h0000_0003);
    apb(0, 8'h30, '0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1, crank_tracker_pkg::WHEEL_OFFSET, 32'h0002_000C);
    apb(1, crank_tracker_pkg::STALL_OFFSET, 32'h0000_0FA0);
    apb(1, crank_tracker_pkg::SKIP_OFFSET, 32'h0000_0002);
    apb(1, crank_tracker_pkg::SUM_LENGTH_OFFSET, 32'h0000_0004);
    apb(1, crank_tracker_pkg::SIM_INTERVAL_OFFSET, 32'h0000_00C8);
    run <= 1;
    ctrl[crank_tracker_pkg::CTRL_PERMIT_BIT] = 1;
    wait_sync();
    wait_idx(16'h0003);
    chk_rd(crank_tracker_pkg::PERIOD_OFFSET, 32'h0000_012C);
    ctrl[crank_tracker_pkg::CTRL_SIM_BIT] = 1;
    ctrl[crank_tracker_pkg::CTRL_PERMIT_BIT] = 0;
    kick(10);
    ctrl[crank_tracker_pkg::CTRL_PERMIT_BIT] = 1;
    wait_sync();
    wait_idx(16'h0001);
    sim_rise();
    for (i = 0; i < 400 && sim_crank === 1'b1; i++) @(negedge clk_i);
    `CHK(i, 16)
    for (; i < 800 && sim_crank !== 1'b1; i++) @(negedge clk_i);
    `CHK(i, 200)
    wait_idx(16'h0005);
    repeat (180) @(negedge clk_i);
    `CHK(angle, 16'h0300)
    chk_rd(crank_tracker_pkg::SUM_OFFSET, 32'h0000_0320);
    chk_rd(crank_tracker_pkg::PERIOD_OFFSET, 32'h0000_00C8);
    wait_idx(16'h0000);
    repeat (3) @(negedge clk_i);
    `CHK(angle < 16'h0010, 1'b1)
    ctrl[crank_tracker_pkg::CTRL_PERMIT_BIT] = 0;
    kick(10);
    ctrl[crank_tracker_pkg::CTRL_FOUR_BIT] = 1;
    ctrl[crank_tracker_pkg::CTRL_PERMIT_BIT] = 1;
    wait_sync();
    mx = '0;
    repeat (60) kick(100);
    `CHK(mx, 16'h0015)
    sim_rise();
    kick(3150);
    `CHK(unsync, 1'b1)
    k = 0;
    repeat (400) @(negedge clk_i) k += int'(sim_crank);
    `CHK(k, 0)
    apb(1, crank_tracker_pkg::SIM_INTERVAL_OFFSET, 32'h0000_0000);
    repeat (4200) @(negedge clk_i);
    `CHK({stall, unsync, index, angle}, 34'h3_0000_0000)
    kick(5);
    chk_rd(crank_tracker_pkg::PERIOD_OFFSET, 32'h0000_0000);
    chk_rd(crank_tracker_pkg::SUM_OFFSET, 32'h0000_0000);
    conclude();
  end
endmodule
`default_nettype wire
